// >>> verilog/mmn_regs.vh
// register offsets, field positions, command codes and timing for the memory map block
`ifndef MMN_REGS_VH
`define MMN_REGS_VH

`define MMN_OFS_CTRL      8'h00
`define MMN_OFS_CMD       8'h04
`define MMN_OFS_STATUS    8'h08
`define MMN_OFS_LOCK      8'h0C
`define MMN_OFS_CALIB     8'h10

`define MMN_CTRL_REMAP    0
`define MMN_ST_LOCKERR    0
`define MMN_ST_SECURE     1
`define MMN_ST_FFPMODE    2
`define MMN_ST_ERPEND     3
`define MMN_ST_NVM_LO     4
`define MMN_CMD_ARG_LO    8
`define MMN_CMD_ARG_HI    18

`define MMN_CMD_PROG      4'h1
`define MMN_CMD_ERASE_PG  4'h2
`define MMN_CMD_FULL_ER   4'h3
`define MMN_CMD_SET_LOCK  4'h4
`define MMN_CMD_CLR_LOCK  4'h5
`define MMN_CMD_SET_NVM   4'h6
`define MMN_CMD_CLR_NVM   4'h7
`define MMN_CMD_SET_SEC   4'h8

`define MMN_NVM_BOD_EN    0
`define MMN_NVM_BOD_RST   1
`define MMN_NVM_BOOT_FL   2

`define MMN_RST_NVM       3'h0
`define MMN_RST_LOCK      32'h00000000
`define MMN_RST_CALIB     16'h5A5A

`define MMN_AREA_INT      4'h0
`define MMN_AREA_EXT_LO   4'h1
`define MMN_AREA_EXT_HI   4'h8
`define MMN_AREA_PERIPH   4'hF
`define MMN_SUB_BOOT      4'h0
`define MMN_SUB_FLASH     4'h1
`define MMN_SUB_SRAM      4'h2
`define MMN_SUB_ROM       4'h3

`define MMN_CLK_KHZ       50000
`define MMN_ERASE_IGN_MS  100
`define MMN_ERASE_ACT_MS  220
`define MMN_ERASE_IGN_CYC 24'h4C4B40
`define MMN_ERASE_ACT_CYC 24'hA7D8C0

`endif

// >>> verilog/mmn_memory_map.v
// first-level decoder, remap, flash lock, security and nvm bit logic
`include "mmn_regs.vh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// - 4 GB split into sixteen 256 MB areas by top four address bits.
// - areas one to eight go to external unit, each its own select.
// - area zero holds internal memories in 1 MB sub-areas.
// - area fifteen goes to the peripheral bridge.
// - any other area returns an abort to the master.
// - sram only at its base until remap, then also at zero.
// - rom always decoded at its fixed base.
// - flash always decoded at its fixed base.
// - with remap clear, nvm bit 2 set aliases flash at zero, clear aliases rom.
// - nvm bits change only by set or clear nvm commands or factory restore; here reset also clears them.
// - factory restore clears nvm bit 2, booting from rom.
// - large configuration keeps 32 lock bits of 64-page regions.
// - small configuration keeps 8 lock bits of 32-page regions.
// - erase or program to locked region aborts and raises interrupt.
// - set-lock protects, clear-lock unprotects; only commands or factory restore change locks; here reset also clears them.
// - factory restore clears every lock bit.
// - secure part refuses flash access from debug or fast port.
// - security set only by command, cleared by restore plus erase.
// - nvm bit 0 enables brownout detector; restore clears it.
// - nvm bit 1 enables brownout reset; restore clears it.
// - sixteen calibration bits read-only, untouched by restore.
// - restore pin ignored under 100 ms, acts after 220 ms held.
module mmn_memory_map #(
    parameter        SMALL_CFG = 0,
    parameter [23:0] ERASE_IGN = `MMN_ERASE_IGN_CYC,
    parameter [23:0] ERASE_ACT = `MMN_ERASE_ACT_CYC
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    input  wire        m_valid,
    input  wire [31:0] m_addr,
    input  wire        m_from_debug,
    input  wire        m_from_ffp,
    output wire        sel_sram,
    output wire        sel_rom,
    output wire        sel_flash,
    output wire        sel_periph,
    output wire [7:0]  ext_select_n,
    output wire        m_abort,
    input  wire        erase_pin,
    input  wire        test_mode_pin,
    input  wire        port_a_line_zero,
    input  wire        port_a_line_one,
    input  wire        port_a_line_two,
    output wire        fast_prog_mode,
    output wire        brownout_detector_en,
    output wire        brownout_reset_en,
    output wire [15:0] calib_bits,
    output wire        flash_irq,
    output wire        flash_prog_go,
    output wire        flash_erase_go,
    output wire        flash_full_erase,
    output wire [10:0] flash_page
);

    localparam [5:0] NLOCK = SMALL_CFG ? 6'd8 : 6'd32;

    // region of a page: 64-page regions, or 32-page in the small part
    function [4:0] lock_region;
        input [10:0] page;
        begin
            if (SMALL_CFG != 0) begin
                lock_region = {2'b00, page[7:5]};
            end else begin
                lock_region = page[10:6];
            end
        end
    endfunction

    function in_lock_range;
        input [4:0] reg_idx;
        begin
            in_lock_range = ({1'b0, reg_idx} < NLOCK);
        end
    endfunction

    // one strobe per command, valid only in a write's data phase
    function cmd_is;
        input       wr;
        input [3:0] code;
        input [3:0] want;
        begin
            cmd_is = wr & (code == want);
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    reg [1:0] erase_sync_reg;
    reg [1:0] tst_sync_reg;
    reg [1:0] pa0_sync_reg;
    reg [1:0] pa1_sync_reg;
    reg [1:0] pa2_sync_reg;

    always @(posedge clk) begin
        if (rst) begin
            erase_sync_reg <= 2'h0;
            tst_sync_reg   <= 2'h0;
            pa0_sync_reg   <= 2'h0;
            pa1_sync_reg   <= 2'h0;
            pa2_sync_reg   <= 2'h0;
        end else begin
            erase_sync_reg <= {erase_sync_reg[0], erase_pin};
            tst_sync_reg   <= {tst_sync_reg[0], test_mode_pin};
            pa0_sync_reg   <= {pa0_sync_reg[0], port_a_line_zero};
            pa1_sync_reg   <= {pa1_sync_reg[0], port_a_line_one};
            pa2_sync_reg   <= {pa2_sync_reg[0], port_a_line_two};
        end
    end

    assign fast_prog_mode = tst_sync_reg[1] & pa0_sync_reg[1] &
                            pa1_sync_reg[1] & ~pa2_sync_reg[1];

    //////////////////////////////////////////////////////////////////////////
    // factory restore debounce: a glitch cannot wipe the flash
    reg [23:0] erase_cnt_reg;
    wire       erase_fire;
    wire       erase_pending;

    always @(posedge clk) begin
        if (rst) begin
            erase_cnt_reg <= 24'h000000;
        end else if (!erase_sync_reg[1]) begin
            erase_cnt_reg <= 24'h000000;
        end else if (erase_cnt_reg <= ERASE_ACT) begin
            erase_cnt_reg <= erase_cnt_reg + 24'h000001;
        end
    end

    // fires once per press, when held past the long time
    assign erase_fire    = erase_sync_reg[1] && (erase_cnt_reg == ERASE_ACT);
    assign erase_pending = erase_sync_reg[1] && (erase_cnt_reg >= ERASE_IGN);

    //////////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states
    reg        dph_wr_reg;
    reg [7:0]  dph_addr_reg;
    reg [31:0] rdata_reg;
    reg        remap_reg;
    reg [2:0]  nvm_reg;
    reg [31:0] lock_reg;
    reg        secure_reg;
    reg        lock_err_reg;
    reg        prog_go_reg;
    reg        erase_go_reg;
    reg        full_go_reg;
    reg [10:0] page_reg;
    reg [31:0] rd_mux;

    wire addr_phase = hsel & htrans[1] & hready;
    wire rd_status  = addr_phase & ~hwrite & (haddr[7:0] == `MMN_OFS_STATUS);

    always @* begin
        case (haddr[7:0])
            `MMN_OFS_CTRL: begin
                rd_mux = {31'h0, remap_reg};
            end
            `MMN_OFS_STATUS: begin
                rd_mux = {25'h0, nvm_reg, erase_pending, fast_prog_mode,
                          secure_reg, lock_err_reg};
            end
            `MMN_OFS_LOCK: begin
                rd_mux = lock_reg;
            end
            `MMN_OFS_CALIB: begin
                rd_mux = {16'h0, calib_bits};
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            dph_wr_reg   <= 1'b0;
            dph_addr_reg <= 8'h00;
            rdata_reg    <= 32'h00000000;
        end else begin
            dph_wr_reg <= addr_phase & hwrite;
            if (addr_phase) begin
                dph_addr_reg <= haddr[7:0];
            end
            if (addr_phase & ~hwrite) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;

    //////////////////////////////////////////////////////////////////////////
    // command decode
    wire        ctrl_wr = dph_wr_reg && (dph_addr_reg == `MMN_OFS_CTRL);
    wire        cmd_wr  = dph_wr_reg && (dph_addr_reg == `MMN_OFS_CMD);
    wire [3:0]  cmd     = hwdata[3:0];
    wire [10:0] arg     = hwdata[`MMN_CMD_ARG_HI:`MMN_CMD_ARG_LO];
    wire [4:0]  region  = lock_region(arg);
    wire        rgn_ok  = in_lock_range(region);
    wire        locked  = lock_reg[region];
    wire        do_prog  = cmd_is(cmd_wr, cmd, `MMN_CMD_PROG);
    wire        do_erase = cmd_is(cmd_wr, cmd, `MMN_CMD_ERASE_PG);
    wire        do_full  = cmd_is(cmd_wr, cmd, `MMN_CMD_FULL_ER);
    wire        do_setl  = cmd_is(cmd_wr, cmd, `MMN_CMD_SET_LOCK);
    wire        do_clrl  = cmd_is(cmd_wr, cmd, `MMN_CMD_CLR_LOCK);
    wire        do_setn  = cmd_is(cmd_wr, cmd, `MMN_CMD_SET_NVM);
    wire        do_clrn  = cmd_is(cmd_wr, cmd, `MMN_CMD_CLR_NVM);
    wire        do_sec   = cmd_is(cmd_wr, cmd, `MMN_CMD_SET_SEC);
    wire        wr_cmd  = do_prog | do_erase;
    wire        viol    = wr_cmd && locked;
    wire        any_lock = |lock_reg;

    always @(posedge clk) begin
        if (rst) begin
            remap_reg <= 1'b0;
        end else if (ctrl_wr) begin
            remap_reg <= hwdata[`MMN_CTRL_REMAP];
        end
    end

    // nvm state modelled as cleared by reset, as on a blank part
    always @(posedge clk) begin
        if (rst) begin
            nvm_reg <= `MMN_RST_NVM;
        end else if (erase_fire) begin
            nvm_reg <= 3'h0;
        end else if (do_setn && (arg < 11'h003)) begin
            nvm_reg[arg[1:0]] <= 1'b1;
        end else if (do_clrn && (arg < 11'h003)) begin
            nvm_reg[arg[1:0]] <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            lock_reg <= `MMN_RST_LOCK;
        end else if (erase_fire) begin
            lock_reg <= 32'h00000000;
        end else if (do_setl && rgn_ok) begin
            lock_reg[region] <= 1'b1;
        end else if (do_clrl && rgn_ok) begin
            lock_reg[region] <= 1'b0;
        end
    end

    // restore pin also runs the full erase, so security drops with it
    always @(posedge clk) begin
        if (rst) begin
            secure_reg <= 1'b0;
        end else if (erase_fire) begin
            secure_reg <= 1'b0;
        end else if (do_sec) begin
            secure_reg <= 1'b1;
        end
    end

    // set beats the clear-on-read of status
    always @(posedge clk) begin
        if (rst) begin
            lock_err_reg <= 1'b0;
        end else if (viol || (do_full && any_lock)) begin
            lock_err_reg <= 1'b1;
        end else if (rd_status) begin
            lock_err_reg <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            prog_go_reg  <= 1'b0;
            erase_go_reg <= 1'b0;
            full_go_reg  <= 1'b0;
            page_reg     <= 11'h000;
        end else begin
            prog_go_reg  <= do_prog && !locked;
            erase_go_reg <= do_erase && !locked;
            full_go_reg  <= erase_fire || (do_full && !any_lock);
            if (wr_cmd) begin
                page_reg <= arg;
            end
        end
    end

    assign flash_irq            = lock_err_reg;
    assign flash_prog_go        = prog_go_reg;
    assign flash_erase_go       = erase_go_reg;
    assign flash_full_erase     = full_go_reg;
    assign flash_page           = page_reg;
    assign brownout_detector_en = nvm_reg[`MMN_NVM_BOD_EN];
    assign brownout_reset_en    = nvm_reg[`MMN_NVM_BOD_RST];
    assign calib_bits           = `MMN_RST_CALIB;

    //////////////////////////////////////////////////////////////////////////
    // address decode, combinational so the access is not delayed
    wire [3:0] area    = m_addr[31:28];
    wire [3:0] sub     = m_addr[23:20];
    wire       int_hi0 = (m_addr[27:24] == 4'h0);
    wire       boot_fl = nvm_reg[`MMN_NVM_BOOT_FL];
    reg        area_int;
    reg        area_ext;
    reg        area_per;
    reg        hit_sram;
    reg        hit_rom;
    reg        hit_fl;

    // first level: each of the sixteen areas has at most one owner
    always @* begin
        area_int = 1'b0;
        area_ext = 1'b0;
        area_per = 1'b0;
        case (area)
            `MMN_AREA_INT: begin
                area_int = int_hi0;
            end
            `MMN_AREA_PERIPH: begin
                area_per = 1'b1;
            end
            default: begin
                area_ext = (area >= `MMN_AREA_EXT_LO) &&
                           (area <= `MMN_AREA_EXT_HI);
            end
        endcase
    end

    // second level: remap wins the boot alias, then the boot bit picks
    always @* begin
        hit_sram = 1'b0;
        hit_rom  = 1'b0;
        hit_fl   = 1'b0;
        if (area_int) begin
            case (sub)
                `MMN_SUB_BOOT: begin
                    if (remap_reg) begin
                        hit_sram = 1'b1;
                    end else if (boot_fl) begin
                        hit_fl = 1'b1;
                    end else begin
                        hit_rom = 1'b1;
                    end
                end
                `MMN_SUB_FLASH: begin
                    hit_fl = 1'b1;
                end
                `MMN_SUB_SRAM: begin
                    hit_sram = 1'b1;
                end
                `MMN_SUB_ROM: begin
                    hit_rom = 1'b1;
                end
                default: begin
                    hit_fl = 1'b0;  // unused 1 MB slots abort
                end
            endcase
        end
    end

    wire       refused  = hit_fl && secure_reg &&
                          (m_from_debug || m_from_ffp || fast_prog_mode);
    wire       hit_any  = hit_sram | hit_rom | hit_fl | area_ext | area_per;
    wire [2:0] ext_idx  = area[2:0] - 3'h1;

    assign sel_sram     = m_valid & hit_sram;
    assign sel_rom      = m_valid & hit_rom;
    assign sel_flash    = m_valid & hit_fl & ~refused;
    assign sel_periph   = m_valid & area_per;
    assign ext_select_n = ~({7'h00, m_valid & area_ext} << ext_idx);
    assign m_abort      = m_valid & (~hit_any | refused);

endmodule // mmn_memory_map

// >>> verification/mmn_memory_map_assertions.sv
// concurrent checks on the decoder, pin and flash-command ports
`include "mmn_regs.vh"
module mmn_memory_map_checker (
    input logic        clk,
    input logic        rst,
    input logic        m_valid,
    input logic [31:0] m_addr,
    input logic        m_from_debug,
    input logic        m_from_ffp,
    input logic        sel_sram,
    input logic        sel_rom,
    input logic        sel_flash,
    input logic        sel_periph,
    input logic [7:0]  ext_select_n,
    input logic        m_abort,
    input logic        test_mode_pin,
    input logic        port_a_line_zero,
    input logic        port_a_line_one,
    input logic        port_a_line_two,
    input logic        fast_prog_mode,
    input logic [15:0] calib_bits,
    input logic        flash_irq,
    input logic        flash_prog_go,
    input logic        flash_erase_go
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [3:0] area = m_addr[31:28];
    wire       fast_pins = test_mode_pin & port_a_line_zero & port_a_line_one & ~port_a_line_two;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    AST_EXT_SELECT: assert property (
        m_valid && area >= 4'h1 && area <= 4'h8
        |-> ext_select_n == ~(8'h01 << (area - 4'h1)) && !m_abort) else $error("bad ext select");
    AST_UNUSED_AREA: assert property (
        m_valid && area >= 4'h9 && area <= 4'hE
        |-> m_abort && ext_select_n == 8'hFF && !sel_periph) else $error("no abort");
    AST_PERIPH: assert property (
        m_valid && area == 4'hF |-> sel_periph && !m_abort) else $error("no periph select");
    AST_ROM_FIXED: assert property (
        m_valid && m_addr[31:20] == 12'h003 |-> sel_rom && !sel_flash) else $error("rom miss");
    AST_SRAM_FIXED: assert property (
        m_valid && m_addr[31:20] == 12'h002 |-> sel_sram && !sel_rom) else $error("sram miss");
    AST_FLASH_FIXED: assert property (
        m_valid && m_addr[31:20] == 12'h001 && !m_from_debug && !m_from_ffp && !fast_prog_mode
        |-> sel_flash && !m_abort) else $error("flash miss");
    // two sync stages, so three stable samples settle the mode
    AST_FAST_MODE: assert property (
        fast_pins [*3] |-> fast_prog_mode) else $error("fast mode not entered");
    AST_CALIB_FIXED: assert property (
        calib_bits == `MMN_RST_CALIB) else $error("calibration changed");
    AST_LOCK_ABORT: assert property (
        $rose(flash_irq) |-> !flash_prog_go && !flash_erase_go) else $error("locked cmd ran");
    cover property (flash_irq);
    cover property (m_valid && sel_sram && m_addr[31:20] == 12'h000);
    cover property (fast_prog_mode);
endmodule // mmn_memory_map_checker

bind mmn_memory_map mmn_memory_map_checker u_chk (
    .clk(clk), .rst(rst), .m_valid(m_valid), .m_addr(m_addr), .m_from_debug(m_from_debug),
    .m_from_ffp(m_from_ffp), .sel_sram(sel_sram), .sel_rom(sel_rom), .sel_flash(sel_flash),
    .sel_periph(sel_periph), .ext_select_n(ext_select_n), .m_abort(m_abort),
    .test_mode_pin(test_mode_pin), .port_a_line_zero(port_a_line_zero),
    .port_a_line_one(port_a_line_one), .port_a_line_two(port_a_line_two),
    .fast_prog_mode(fast_prog_mode), .calib_bits(calib_bits), .flash_irq(flash_irq),
    .flash_prog_go(flash_prog_go), .flash_erase_go(flash_erase_go));

// >>> verification/mmn_bus_master.sv
// system bus master model driving the decoder's access side
module mmn_bus_master (
    input  logic        clk,
    output logic        m_valid,
    output logic [31:0] m_addr,
    output logic        m_from_debug,
    output logic        m_from_ffp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        m_valid = 1'b0;
        m_addr = 32'h0;
        m_from_debug = 1'b0;
        m_from_ffp = 1'b0;
    end
    // request stays up until the next call, so the decode can be looked at
    task automatic access(input logic [31:0] a, input logic dbg, input logic ffp);
        @(posedge clk);
        m_valid <= 1'b1;
        m_addr <= a;
        m_from_debug <= dbg;
        m_from_ffp <= ffp;
    endtask
endmodule // mmn_bus_master

// >>> verification/tb_memory_map_nvm_protection.sv
// self-checking bench for the memory map and nvm protection block
`include "mmn_regs.vh"
module tb_memory_map_nvm_protection;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, erase_pin = 0;
    logic tst = 0, pa0 = 0, pa1 = 0, pa2 = 0;
    logic [31:0] haddr = 0, hwdata = 0, rdata, m_addr;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic [15:0] calib;
    logic [10:0] fpage;
    logic [7:0]  ext_n;
    logic        hreadyout, hresp, m_valid, dbg, ffp, s_sram, s_rom, s_flash, s_per, abt;
    logic        ffm, brownout_detector, bod_rst, irq, p_go, e_go, f_er;
    logic [31:0] hrdata;
    wire         hready = hreadyout;
    int          error_cnt = 0, check_count = 0, fe_cnt = 0;
    // {address, {sram,rom,flash,periph,abort}, chip selects} at reset state
    logic [44:0] rows [11] = '{
        {32'h00000000, 5'h08, 8'hFF}, {32'h00100000, 5'h04, 8'hFF}, {32'h00200000, 5'h10, 8'hFF},
        {32'h00300000, 5'h08, 8'hFF}, {32'h00400000, 5'h01, 8'hFF}, {32'h01000000, 5'h01, 8'hFF},
        {32'h10000000, 5'h00, 8'hFE}, {32'h80000000, 5'h00, 8'h7F}, {32'h90000000, 5'h01, 8'hFF},
        {32'hE0000000, 5'h01, 8'hFF}, {32'hF0000000, 5'h02, 8'hFF}};
    ////////////////////////////////////////////////////////////////////////////
    mmn_memory_map #(.SMALL_CFG(0), .ERASE_IGN(24'hA), .ERASE_ACT(24'h14)) dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .m_valid(m_valid), .m_addr(m_addr), .m_from_debug(dbg),
        .m_from_ffp(ffp), .sel_sram(s_sram), .sel_rom(s_rom), .sel_flash(s_flash),
        .sel_periph(s_per), .ext_select_n(ext_n), .m_abort(abt), .erase_pin(erase_pin),
        .test_mode_pin(tst), .port_a_line_zero(pa0), .port_a_line_one(pa1),
        .port_a_line_two(pa2), .fast_prog_mode(ffm), .brownout_detector_en(brownout_detector),
        .brownout_reset_en(bod_rst), .calib_bits(calib), .flash_irq(irq),
        .flash_prog_go(p_go), .flash_erase_go(e_go), .flash_full_erase(f_er),
        .flash_page(fpage));
    mmn_bus_master mst (.clk(clk), .m_valid(m_valid), .m_addr(m_addr), .m_from_debug(dbg),
        .m_from_ffp(ffp));
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (f_er === 1'b1) fe_cnt++;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask
    task automatic sel(input logic [31:0] a, input logic d, input logic f, input logic [4:0] e);
        mst.access(a, d, f);
        #1;
        chk("selects", {s_sram, s_rom, s_flash, s_per, abt}, e);
    endtask
    task automatic pins(input logic [3:0] v, input int n);
        @(posedge clk);
        {tst, pa0, pa1, pa2} <= v;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic press(input int n);
        @(posedge clk);
        erase_pin <= 1'b1;
        repeat (n) @(posedge clk);
        erase_pin <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        error_cnt++;
        end_sim;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            sel(rows[i][44:13], 1'b0, 1'b0, rows[i][12:8]);
            chk("ext_select_n", ext_n, rows[i][7:0]);
        end
        ahb(1'b1, `MMN_OFS_CTRL, 32'h1);
        sel(32'h0, 1'b0, 1'b0, 5'h10);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        sel(32'h0, 1'b0, 1'b0, 5'h08);
        for (int b = 0; b < 3; b++) ahb(1'b1, `MMN_OFS_CMD, (b << 8) | 32'h6);
        sel(32'h0, 1'b0, 1'b0, 5'h04);
        chk("bod", {brownout_detector, bod_rst}, 2'h3);
        ahb(1'b1, `MMN_OFS_CMD, 32'h7);
        #1;
        chk("bod", brownout_detector, 1'b0);
        ahb(1'b1, `MMN_OFS_CMD, 32'h6);
        ahb(1'b1, `MMN_OFS_CMD, 32'h4004);
        ahb(1'b0, `MMN_OFS_LOCK, 0);
        chk("lock", rdata, 32'h2);
        ahb(1'b1, `MMN_OFS_CMD, 32'h7F01);
        #1;
        chk("locked prog", {p_go, irq}, 2'h1);
        ahb(1'b1, `MMN_OFS_CMD, 32'h4002);
        #1;
        chk("locked erase", {e_go, irq}, 2'h1);
        ahb(1'b0, `MMN_OFS_STATUS, 0);
        chk("status", rdata & 32'h71, 32'h71);
        ahb(1'b1, `MMN_OFS_CMD, 32'h3F01);
        #1;
        chk("prog", {p_go, irq, fpage}, {2'h2, 11'h03F});
        ahb(1'b1, `MMN_OFS_CMD, 32'h2002);
        #1;
        chk("erase", {e_go, irq, fpage}, {2'h2, 11'h020});
        ahb(1'b1, `MMN_OFS_CMD, 32'h7F05);
        ahb(1'b0, `MMN_OFS_LOCK, 0);
        chk("unlock", rdata, 32'h0);
        ahb(1'b1, `MMN_OFS_CMD, 32'h3);
        #1;
        chk("full erase", {f_er, irq, hresp}, 3'h4);
        ahb(1'b1, `MMN_OFS_CMD, 32'h4004);
        ahb(1'b1, `MMN_OFS_CMD, 32'h3);
        #1;
        chk("locked full", {f_er, irq}, 2'h1);
        ahb(1'b1, `MMN_OFS_CALIB, 32'h0);
        ahb(1'b0, `MMN_OFS_CALIB, 0);
        chk("calib", rdata, 32'h5A5A);
        ahb(1'b0, 32'h20, 0);
        chk("unmapped", rdata, 32'h0);
        ahb(1'b1, `MMN_OFS_CMD, 32'h8);
        sel(32'h00100000, 1'b1, 1'b0, 5'h01);
        sel(32'h00100000, 1'b0, 1'b1, 5'h01);
        sel(32'h00100000, 1'b0, 1'b0, 5'h04);
        pins(4'hE, 3);
        chk("fast mode", ffm, 1'b1);
        pins(4'hF, 3);
        chk("fast mode", ffm, 1'b0);
        press(8);
        chk("short press", {brownout_detector, bod_rst}, 2'h3);
        press(40);
        chk("restore", {brownout_detector, bod_rst, fe_cnt[1:0]}, 4'h2);
        ahb(1'b0, `MMN_OFS_LOCK, 0);
        chk("restore lock", rdata, 32'h0);
        ahb(1'b0, `MMN_OFS_STATUS, 0);
        chk("restore status", rdata & 32'h72, 32'h0);
        sel(32'h0, 1'b0, 1'b0, 5'h08);
        chk("calib pins", calib, 16'h5A5A);
        end_sim;
    end
endmodule // tb_memory_map_nvm_protection
